// *** hw/cfam_core.sv ***
// Character fetch address map: pointer register, processor-side mapping of the
// shared ROM/IO range and the video-side cell fetch sequencer.
// Assumes memories answer within the cycle their address is presented.

`timescale 1ns/1ns
`default_nettype none

module cfam_core (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  // Processor side
  input  wire logic [15:0]            cpu_addr_i,
  input  wire logic                   cpu_we_i,
  input  wire logic                   cpu_re_i,
  input  wire logic [7:0]             cpu_wdata_i,
  output logic      [7:0]             cpu_rdata_o,
  output logic                        cpu_rvalid_o,
  output cfam_pkg::cfam_cpu_map_t     cpu_map_o,
  output logic      [cfam_pkg::ROM_AW-1:0] cpu_rom_addr_o,
  // Bank select pins from the external interface port
  input  wire logic [1:0]             bank_pins_i,
  // Cell request
  input  wire logic                   cell_req_i,
  input  wire logic [9:0]             cell_index_i,
  input  wire logic [2:0]             cell_row_i,
  output logic                        cell_ready_o,
  // Video memory side
  output cfam_pkg::cfam_vid_bus_t     vid_bus_o,
  output logic      [cfam_pkg::ROM_AW-1:0] rom_addr_o,
  output logic      [2:0]             rom_block_o,
  output logic                        col_rd_o,
  output logic      [9:0]             col_addr_o,
  input  wire logic [7:0]             ram_data_i,
  input  wire logic [7:0]             rom_data_i,
  input  wire logic [3:0]             col_data_i,
  // Dot stream
  output logic                        dot_valid_o,
  output logic                        dot_o,
  output logic      [3:0]             dot_color_o
);
  import cfam_pkg::*;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Overlay only in banks 0 and 2, window 0x1000-0x1FFF of the view
  function automatic logic rom_overlay(input logic [1:0] bank, input logic [13:0] a);
    rom_overlay = ((bank == BANK_0) || (bank == BANK_2)) && (a[13:12] == OVERLAY_WINDOW);
  endfunction

  function automatic logic in_shared(input logic [15:0] a);
    in_shared = (a >= SHARED_LO_ADDR) && (a <= SHARED_HI_ADDR);
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] video_memory_pointer;
  logic [7:0] cpu_port;

  wire       io_visible = cpu_port[PORT_ROM_OFF];
  wire       ptr_hit    = io_visible && (cpu_addr_i == VIDEO_MEMORY_POINTER_ADDR);
  wire       port_hit   = (cpu_addr_i == CPU_PORT_ADDR);
  wire [7:0] read_mux   = ptr_hit ? video_memory_pointer : cpu_port;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      video_memory_pointer <= VIDEO_MEMORY_POINTER_RST;
      cpu_port             <= CPU_PORT_RST;
      cpu_rdata_o          <= 8'h00;
      cpu_rvalid_o         <= 1'b0;
    end else begin
      if (cpu_we_i && ptr_hit) begin
        video_memory_pointer <= cpu_wdata_i;
      end
      if (cpu_we_i && port_hit) begin
        cpu_port <= cpu_wdata_i;
      end
      cpu_rvalid_o <= cpu_re_i && (ptr_hit || port_hit);
      cpu_rdata_o  <= (cpu_re_i && (ptr_hit || port_hit)) ? read_mux : 8'h00;
    end
  end

  // ==========================================================================
  // Processor-side map
  // ==========================================================================
  // ROM and I/O share one range; the port bit picks exactly one
  wire in_range = in_shared(cpu_addr_i);

  // One driver for the whole map word: {ram, rom, io}
  assign cpu_map_o       = {!in_range, in_range && !io_visible, in_range && io_visible};
  assign cpu_rom_addr_o  = cpu_addr_i[ROM_AW-1:0];

  // ==========================================================================
  // Video fetch sequencer
  // ==========================================================================
  cfam_state_t state;
  cfam_state_t next_state;
  logic [9:0]  cell_q;
  logic [2:0]  row_q;
  logic [7:0]  code_q;
  logic [7:0]  shift_q;
  logic [2:0]  dot_cnt;

  wire [1:0]  bank       = ~bank_pins_i;
  wire [2:0]  set_sel    = video_memory_pointer[PTR_CHARSET_MSB:PTR_CHARSET_LSB];
  wire [3:0]  screen_sel = video_memory_pointer[PTR_SCREEN_MSB:PTR_SCREEN_LSB];
  wire [13:0] matrix_a   = {screen_sel, cell_q};
  // In banks 0 and 2, any video fetch in the overlay window, screen code included, reads the ROM
  wire [7:0]  glyph_in   = vid_bus_o.rom_sel ? rom_data_i : ram_data_i;
  wire [13:0] glyph_a    = {set_sel, glyph_in, row_q};
  wire [13:0] next_a     = (state == ST_MATRIX) ? glyph_a : matrix_a;

  assign cell_ready_o = (state == ST_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = cell_req_i ? ST_MATRIX : ST_IDLE;
      ST_MATRIX: next_state = ST_GLYPH;
      ST_GLYPH:  next_state = ST_DOTS;
      ST_DOTS:   next_state = (dot_cnt == 3'(DOT_LAST)) ? ST_IDLE : ST_DOTS;
      default:   next_state = ST_IDLE;
    endcase
  end

  wire load_fetch = (state == ST_IDLE && cell_req_i) || (state == ST_MATRIX);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cell_q    <= 10'h000;
      row_q     <= 3'h0;
      code_q    <= 8'h00;
      vid_bus_o <= '0;
      col_rd_o  <= 1'b0;
      col_addr_o <= 10'h000;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && cell_req_i) begin
        cell_q <= cell_index_i;
        row_q  <= cell_row_i;
      end
      if (state == ST_MATRIX) begin
        code_q <= glyph_in;
      end
      // Screen code and colour go out together
      col_rd_o   <= (state == ST_IDLE) && cell_req_i;
      col_addr_o <= (state == ST_IDLE && cell_req_i) ? cell_index_i : col_addr_o;
      if (load_fetch) begin
        vid_bus_o.rd      <= 1'b1;
        vid_bus_o.addr    <= {bank, (state == ST_MATRIX) ? glyph_a : {screen_sel, cell_index_i}};
        vid_bus_o.rom_sel <= rom_overlay(bank, (state == ST_MATRIX) ? next_a
                                               : {screen_sel, cell_index_i});
      end else begin
        vid_bus_o <= '0;
      end
    end
  end

  // ROM is addressed by the low 12 bits of the view address
  assign rom_addr_o  = vid_bus_o.addr[ROM_AW-1:0];
  assign rom_block_o = vid_bus_o.addr[ROM_AW-1:9];

  // ==========================================================================
  // Dot serialiser
  // ==========================================================================
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_q     <= 8'h00;
      dot_cnt     <= 3'h0;
      dot_valid_o <= 1'b0;
      dot_o       <= 1'b0;
      dot_color_o <= 4'h0;
    end else begin
      if (state == ST_MATRIX) begin
        dot_color_o <= col_data_i;
      end
      if (state == ST_GLYPH) begin
        shift_q     <= {glyph_in[6:0], 1'b0};
        dot_o       <= glyph_in[7];
        dot_valid_o <= 1'b1;
        dot_cnt     <= 3'h0;
      end else if (state == ST_DOTS && dot_cnt != 3'(DOT_LAST)) begin
        shift_q <= {shift_q[6:0], 1'b0};
        dot_o   <= shift_q[7];
        dot_cnt <= dot_cnt + 3'h1;
      end else begin
        dot_valid_o <= 1'b0;
        dot_o       <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  property p_no_rom_odd_bank;
    vid_bus_o.rom_sel |-> (vid_bus_o.addr[15:14] == BANK_0 || vid_bus_o.addr[15:14] == BANK_2);
  endproperty
  a_no_rom_odd_bank: assert property (p_no_rom_odd_bank) else $error("ROM shown in bank 1 or 3");

  property p_bank0_overlay;
    (vid_bus_o.rd && vid_bus_o.addr[15:12] == 4'h1) |-> vid_bus_o.rom_sel;
  endproperty
  a_bank0_overlay: assert property (p_bank0_overlay) else $error("Bank 0 overlay missing");

  property p_bank2_overlay;
    (vid_bus_o.rd && vid_bus_o.addr[15:12] == 4'h9) |-> vid_bus_o.rom_sel;
  endproperty
  a_bank2_overlay: assert property (p_bank2_overlay) else $error("Bank 2 overlay missing");

  property p_cpu_exclusive;
    !(cpu_map_o.rom && cpu_map_o.io) && (cpu_map_o.rom -> in_shared(cpu_addr_i));
  endproperty
  a_cpu_exclusive: assert property (p_cpu_exclusive) else $error("ROM and IO overlap");

  property p_port_maps_rom;
    (cpu_we_i && port_hit && !cpu_wdata_i[PORT_ROM_OFF]) |=> (!io_visible && !ptr_hit);
  endproperty
  a_port_maps_rom: assert property (p_port_maps_rom) else $error("Port write did not map ROM");

  property p_code_and_colour;
    (state == ST_MATRIX) |-> (col_rd_o && vid_bus_o.rd && col_addr_o == cell_q);
  endproperty
  a_code_and_colour: assert property (p_code_and_colour) else $error("Colour not fetched with code");

  property p_glyph_addr;
    (state == ST_GLYPH) |-> (vid_bus_o.addr == {bank, set_sel, code_q, row_q});
  endproperty
  a_glyph_addr: assert property (p_glyph_addr) else $error("Glyph address wrong");

  property p_msb_first;
    (state == ST_GLYPH) |=> (dot_valid_o && dot_o == $past(glyph_in[7]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("First dot not bit 7");

  property p_eight_dots;
    $rose(dot_valid_o) |-> dot_valid_o [*8] ##1 !dot_valid_o;
  endproperty
  a_eight_dots: assert property (p_eight_dots) else $error("Row not eight dots");

endmodule

`default_nettype wire

// *** inc/cfam_pkg.sv ***
// Constants and carrier types for the character fetch address map block.
// Assumes one clock domain; memories and the glyph ROM sit outside.

package cfam_pkg;

  // ==========================================================================
  // Processor-side addresses and reset values
  // ==========================================================================
  localparam logic [15:0] VIDEO_MEMORY_POINTER_ADDR = 16'hD018;
  localparam logic [15:0] CPU_PORT_ADDR             = 16'h0001;
  localparam logic [15:0] SHARED_LO_ADDR            = 16'hD000;
  localparam logic [15:0] SHARED_HI_ADDR            = 16'hDFFF;
  localparam logic [7:0]  VIDEO_MEMORY_POINTER_RST  = 8'h14;
  localparam logic [7:0]  CPU_PORT_RST              = 8'h37;

  // Field positions
  localparam int PTR_SCREEN_MSB  = 7;
  localparam int PTR_SCREEN_LSB  = 4;
  localparam int PTR_CHARSET_MSB = 3;
  localparam int PTR_CHARSET_LSB = 1;
  localparam int PORT_ROM_OFF    = 2;

  // ==========================================================================
  // Video-side geometry
  // ==========================================================================
  localparam int GLYPH_COUNT   = 256;
  localparam int GLYPH_BYTES   = 8;
  localparam int SET_BYTES     = GLYPH_COUNT * GLYPH_BYTES;
  localparam int CHARSET_SLOTS = 8;
  localparam int ROM_BYTES     = 2 * SET_BYTES;
  localparam int ROM_AW        = 12;
  localparam int DOT_LAST      = GLYPH_BYTES - 1;

  // Overlay window inside a 16K view, as address bits 13:12
  localparam logic [1:0] OVERLAY_WINDOW = 2'b01;
  localparam logic [1:0] BANK_0         = 2'd0;
  localparam logic [1:0] BANK_2         = 2'd2;

  // Glyph ROM block contents, 512 bytes each, indexed by ROM address 11:9
  localparam logic [2:0] ROM_BLK_UPPER        = 3'h0;
  localparam logic [2:0] ROM_BLK_GRAPHICS     = 3'h1;
  localparam logic [2:0] ROM_BLK_REV_UPPER    = 3'h2;
  localparam logic [2:0] ROM_BLK_REV_GRAPHICS = 3'h3;
  localparam logic [2:0] ROM_BLK_LOWER        = 3'h4;
  localparam logic [2:0] ROM_BLK_UPPER_GFX    = 3'h5;
  localparam logic [2:0] ROM_BLK_REV_LOWER    = 3'h6;
  localparam logic [2:0] ROM_BLK_REV_UPR_GFX  = 3'h7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {ST_IDLE, ST_MATRIX, ST_GLYPH, ST_DOTS} cfam_state_t;

  typedef struct packed {
    logic        rd;
    logic        rom_sel;
    logic [15:0] addr;
  } cfam_vid_bus_t;

  typedef struct packed {
    logic ram;
    logic rom;
    logic io;
  } cfam_cpu_map_t;

endpackage

// *** verif/cfam_mem_model.sv ***
// Behavioural memories facing the fetch block: RAM, glyph ROM and colour memory.
// Assumes one address per cycle and data taken back in that same cycle.
`timescale 1ns/1ns
`default_nettype none

module cfam_mem_model (
  input  wire logic                     mclk_i,
  input  wire cfam_pkg::cfam_vid_bus_t  vid_bus_i,
  input  wire logic [cfam_pkg::ROM_AW-1:0] rom_addr_i,
  input  wire logic                     col_rd_i,
  input  wire logic [9:0]               col_addr_i,
  output logic      [7:0]               ram_data_o,
  output logic      [7:0]               rom_data_o,
  output logic      [3:0]               col_data_o
);
  import cfam_pkg::*;
  // ==========================================================================
  // Data lines
  // ==========================================================================
  // Unread RAM and colour lines churn so a stale value never looks like a good answer; ROM data always follows its address
  logic [7:0] churn = 8'h00;
  always @(posedge mclk_i) churn <= churn + 8'h3B;
  assign ram_data_o = vid_bus_i.rd ? (vid_bus_i.addr[7:0] ^ vid_bus_i.addr[15:8]) : churn;
  assign rom_data_o = rom_addr_i[7:0] + {rom_addr_i[11:8], 4'h5};
  assign col_data_o = col_rd_i ? (col_addr_i[3:0] ^ col_addr_i[9:6]) : churn[3:0];
endmodule

`default_nettype wire

// *** verif/char_fetch_address_map_test.sv ***
// Self-checking bench for the character fetch address map core.
// Assumes the behavioural memory model answers in the cycle of each read.
`timescale 1ns/1ns
`default_nettype none

module char_fetch_address_map_test;
  import cfam_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic            mclk_i = 1'b0;
  logic            reset_n_i;
  logic [15:0]     cpu_addr_i;
  logic            cpu_we_i;
  logic            cpu_re_i;
  logic [7:0]      cpu_wdata_i;
  logic [7:0]      cpu_rdata_o;
  logic            cpu_rvalid_o;
  cfam_cpu_map_t   cpu_map_o;
  logic [11:0]     cpu_rom_addr_o;
  logic [1:0]      bank_pins_i;
  logic            cell_req_i;
  logic [9:0]      cell_index_i;
  logic [2:0]      cell_row_i;
  logic            cell_ready_o;
  cfam_vid_bus_t   vid_bus_o;
  logic [11:0]     rom_addr_o;
  logic [2:0]      rom_block_o;
  logic            col_rd_o;
  logic [9:0]      col_addr_o;
  logic [7:0]      ram_data_i;
  logic [7:0]      rom_data_i;
  logic [3:0]      col_data_i;
  logic            dot_valid_o;
  logic            dot_o;
  logic [3:0]      dot_color_o;
  int              err_count = 0;
  int              check_count = 0;
  int              cycles = 0;
  logic [31:0]     exp_q[$];
  logic [7:0]      ptr_exp = 8'h14;
  logic [15:0]     addrs[6] = '{16'h1000, 16'hCFFF, 16'hD000, 16'hD018, 16'hDFFF, 16'hE000};

  always #4 mclk_i = ~mclk_i;

  cfam_core u_cfam_core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cpu_addr_i(cpu_addr_i), .cpu_we_i(cpu_we_i),
    .cpu_re_i(cpu_re_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o),
    .cpu_map_o(cpu_map_o), .cpu_rom_addr_o(cpu_rom_addr_o), .bank_pins_i(bank_pins_i), .cell_req_i(cell_req_i),
    .cell_index_i(cell_index_i), .cell_row_i(cell_row_i), .cell_ready_o(cell_ready_o), .vid_bus_o(vid_bus_o),
    .rom_addr_o(rom_addr_o), .rom_block_o(rom_block_o), .col_rd_o(col_rd_o), .col_addr_o(col_addr_o),
    .ram_data_i(ram_data_i), .rom_data_i(rom_data_i), .col_data_i(col_data_i), .dot_valid_o(dot_valid_o),
    .dot_o(dot_o), .dot_color_o(dot_color_o));

  cfam_mem_model u_cfam_mem_model (.mclk_i(mclk_i), .vid_bus_i(vid_bus_o), .rom_addr_i(rom_addr_o),
    .col_rd_i(col_rd_o), .col_addr_i(col_addr_o), .ram_data_o(ram_data_i), .rom_data_o(rom_data_i),
    .col_data_o(col_data_i));

  // ==========================================================================
  // Checking
  // ==========================================================================
  function automatic logic [7:0] ram_f(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [7:0] rom_f(input logic [11:0] a);
    return a[7:0] + {a[11:8], 4'h5};
  endfunction
  function automatic logic [31:0] vexp(input logic s, input logic [15:0] a);
    return {8'h02, 3'b000, s, 1'b0, a[11:9], a};
  endfunction

  task automatic end_sim();
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Unexpected results meet an impossible expectation
  task automatic take(input logic [31:0] seen);
    if (exp_q.size() == 0) check(seen, 32'hFFFFFFFF);
    else check(seen, exp_q.pop_front());
  endtask

  always @(negedge mclk_i) begin
    if (cpu_rvalid_o === 1'b1) take({24'h010000, cpu_rdata_o});
    if (col_rd_o === 1'b1) take({20'h03000, 2'b00, col_addr_o});
    if (vid_bus_o.rd === 1'b1) take({8'h02, 3'b000, vid_bus_o.rom_sel, 1'b0, rom_block_o, vid_bus_o.addr});
    if (dot_valid_o === 1'b1) take({8'h04, 16'h0000, 3'b000, dot_o, dot_color_o});
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles >= 5000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================================
  // Drivers, called at a falling edge
  // ==========================================================================
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu_addr_i = a;
    cpu_wdata_i = d;
    cpu_we_i = 1'b1;
    @(negedge mclk_i) cpu_we_i = 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic rd(input logic [15:0] a, input logic hit, input logic [7:0] d);
    if (hit) exp_q.push_back({24'h010000, d});
    cpu_addr_i = a;
    cpu_re_i = 1'b1;
    @(negedge mclk_i) cpu_re_i = 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic map_chk(input logic [15:0] a, input logic b2);
    logic in;
    cpu_addr_i = a;
    in = a >= SHARED_LO_ADDR && a <= SHARED_HI_ADDR;
    #1;
    check({29'h0, cpu_map_o}, {29'h0, in ? {1'b0, !b2, b2} : 3'b100});
    check({20'h0, cpu_rom_addr_o}, {20'h0, a[11:0]});
    @(negedge mclk_i);
  endtask

  // Leaves the request up so a following call runs back to back
  task automatic fetch(input logic [1:0] bank, input logic [9:0] idx, input logic [2:0] row);
    logic [15:0] ma, ga;
    logic ms, gs;
    logic [7:0] code, byt;
    ma = {bank, ptr_exp[7:4], idx};
    ms = (bank == BANK_0 || bank == BANK_2) && ma[13:12] == OVERLAY_WINDOW;
    code = ms ? rom_f(ma[11:0]) : ram_f(ma);
    ga = {bank, ptr_exp[3:1], code, row};
    gs = (bank == BANK_0 || bank == BANK_2) && ga[13:12] == OVERLAY_WINDOW;
    byt = gs ? rom_f(ga[11:0]) : ram_f(ga);
    exp_q.push_back({20'h03000, 2'b00, idx});
    exp_q.push_back(vexp(ms, ma));
    exp_q.push_back(vexp(gs, ga));
    for (int i = 7; i >= 0; i--) exp_q.push_back({8'h04, 16'h0000, 3'b000, byt[i], idx[3:0] ^ idx[9:6]});
    cell_index_i = idx;
    cell_row_i = row;
    cell_req_i = 1'b1;
    while (cell_ready_o !== 1'b1) @(negedge mclk_i);
    @(negedge mclk_i);
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    void'($urandom(33372));
    {cpu_addr_i, cpu_we_i, cpu_re_i, cpu_wdata_i, cell_req_i, cell_index_i, cell_row_i} = '0;
    reset_n_i = 1'b0;
    bank_pins_i = 2'b11;
    repeat (5) @(negedge mclk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    rd(VIDEO_MEMORY_POINTER_ADDR, 1'b1, VIDEO_MEMORY_POINTER_RST);
    rd(CPU_PORT_ADDR, 1'b1, CPU_PORT_RST);
    foreach (addrs[k]) map_chk(addrs[k], 1'b1);
    // No interrupt source in this bench, so none can land while I/O is out
    wr(CPU_PORT_ADDR, 8'h33);
    foreach (addrs[k]) map_chk(addrs[k], 1'b0);
    for (int k = 0; k < 6; k++) map_chk(16'($urandom()), 1'b0);
    // Pointer is hidden while the ROM is mapped in
    wr(VIDEO_MEMORY_POINTER_ADDR, 8'hFF);
    rd(VIDEO_MEMORY_POINTER_ADDR, 1'b0, 8'h00);
    rd(CPU_PORT_ADDR, 1'b1, 8'h33);
    wr(CPU_PORT_ADDR, CPU_PORT_RST);
    rd(VIDEO_MEMORY_POINTER_ADDR, 1'b1, VIDEO_MEMORY_POINTER_RST);
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 8; c++) begin
        while (exp_q.size() != 0) @(negedge mclk_i);
        bank_pins_i = 2'(p);
        // Odd steps change only the set base and bit 0 and keep the screen nibble
        ptr_exp = {c[0] ? ptr_exp[7:4] : 4'($urandom()), 3'(c), 1'($urandom())};
        wr(VIDEO_MEMORY_POINTER_ADDR, ptr_exp);
        rd(VIDEO_MEMORY_POINTER_ADDR, 1'b1, ptr_exp);
        fetch(~2'(p), 10'($urandom()), 3'($urandom()));
        fetch(~2'(p), 10'($urandom()), 3'($urandom()));
        cell_req_i = 1'b0;
      end
    end
    while (exp_q.size() != 0) @(negedge mclk_i);
    repeat (2) @(negedge mclk_i);
    end_sim();
  end
endmodule

`default_nettype wire
